/* fpp_defs.svh */
`ifndef FPP_DEFS_SVH
`define FPP_DEFS_SVH

`define FPP_ST_RSVD     2'h0
`define FPP_ST_XFER     2'h1
`define FPP_ST_STAT     2'h2
`define FPP_ST_ID       2'h3
`define FPP_ID_FMT9     8'h5A
`define FPP_ID_FMT11    8'hA5
`define FPP_GEN1        15:11
`define FPP_GEN2        10:6
`define FPP_OP11        5:2
`define FPP_F11         0
`define FPP_OP9         5:3
`define FPP_F9          2
`define FPP_I9          1:0
`define FPP_GEN_REG_MAX 5'h07
`define FPP_I_BYTE      2'h0
`define FPP_I_WORD      2'h1
`define FPP_WORDS_1     3'h1
`define FPP_WORDS_2     3'h2
`define FPP_WORDS_4     3'h4
`define FPP_OP2_BASE    3'h4
`define FPP_SW_QUIT     0
`define FPP_SW_L        2
`define FPP_SW_Z        6
`define FPP_SW_N        7
`define FPP_TT          2:0
`define FPP_TT_ILL      3'h5
`define FPP_TT_DVZ      3'h6
`define FPP_CLK_MHZ     20
`define FPP_PULSE_NS    50
`define FPP_PULSE_CYC   8'(((`FPP_PULSE_NS * `FPP_CLK_MHZ) + 999) / 1000)
`define FPP_ECHO_CYC    8'h04
`define FPP_RST_MIN_CYC 64
`define FPP_A_CTRL      8'h00
`define FPP_A_STATE     8'h04
`define FPP_A_FSR       8'h08
`define FPP_A_OPW       8'h0C
`define FPP_SYNC_RST    19'h40000
`endif

/* fpp_pkg.sv */
`default_nettype none
package fpp_pkg;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_OPW   = 3'b001,
      ST_OPND  = 3'b010,
      ST_EXEC  = 3'b011,
      ST_PULSE = 3'b100,
      ST_ECHO  = 3'b101,
      ST_STAT  = 3'b110,
      ST_RES   = 3'b111
   } fpp_state_t;
   typedef enum logic [4:0] {
      OP_ADD = 5'b00000, OP_SUB = 5'b00001, OP_MUL = 5'b00010, OP_DIV = 5'b00011,
      OP_MOV = 5'b00100, OP_ABS = 5'b00101, OP_NEG = 5'b00110, OP_CMP = 5'b00111,
      OP_FLR = 5'b01000, OP_TRC = 5'b01001, OP_RND = 5'b01010, OP_WID = 5'b01011,
      OP_NAR = 5'b01100, OP_I2F = 5'b01101, OP_LDS = 5'b01110, OP_STS = 5'b01111,
      OP_ILL = 5'b10000
   } fpp_op_t;
endpackage
`default_nettype wire

/* fpp_sync.sv */
`default_nettype none
module fpp_sync #(
   parameter int unsigned  W  = 1,
   parameter logic [W-1:0] RV = '0
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // levels in and out
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   // two flops; the first is read only by the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= RV;
         q      <= RV;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule
`default_nettype wire

/* fpp_port.sv */
`include "fpp_defs.svh"
`default_nettype none
module fpp_port #(
   parameter logic [7:0] EXEC_CYCLES = 8'h08,
   parameter logic [7:0] ID_FMT9     = `FPP_ID_FMT9,
   parameter logic [7:0] ID_FMT11    = `FPP_ID_FMT11
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // host protocol pins
   input  wire logic        status_line_low,
   input  wire logic        status_line_high,
   input  wire logic        handshake_strobe_n_i,
   output logic             handshake_strobe_n_o,
   output logic             handshake_strobe_n_oe,
   input  wire logic [15:0] data_i,
   output logic      [15:0] data_o,
   output logic             data_oe
);
   fpp_pkg::fpp_state_t state_q;
   fpp_pkg::fpp_op_t    op_c;
   logic [18:0] sync_q;
   logic        spc_s;
   logic [1:0]  code_s;
   logic [15:0] dat_s;
   logic        spc_d1_q;
   logic        guard;
   logic        fall;
   logic        rise;
   logic [1:0]  code_q;
   logic        fmt11_q;
   logic [15:0] opword_q;
   logic [15:0] opm_q [0:7];
   logic [2:0]  wcnt_q;
   logic [2:0]  rcnt_q;
   logic [7:0]  cnt_q;
   logic [15:0] res_q [0:3];
   logic [15:0] sw_q;
   logic [31:0] fsr_q;
   logic        inject_q;
   logic        fl;
   logic [2:0]  fs;
   logic [2:0]  is;
   logic        g1r;
   logic        g2r;
   logic [2:0]  n1;
   logic [2:0]  n2;
   logic [2:0]  nr;
   logic [2:0]  ntot;
   logic [2:0]  widx;
   logic [63:0] a1;
   logic [63:0] a2;
   logic [63:0] res_c;
   logic        quit_c;
   logic [2:0]  tt_c;
   logic        eq_c;
   logic        gt_c;
   logic        id_wr;
   logic        x_wr;
   logic        s_go;
   logic        r_go;
   logic [31:0] rd_c;
   logic        map_c;

   function automatic logic [2:0] fsize(input logic single);
      fsize = single ? `FPP_WORDS_2 : `FPP_WORDS_4;
   endfunction

   function automatic logic [2:0] isize(input logic [1:0] i);
      isize = (i == `FPP_I_BYTE || i == `FPP_I_WORD) ? `FPP_WORDS_1 : `FPP_WORDS_2;
   endfunction

   function automatic logic [63:0] mag(input logic [63:0] v, input logic single);
      mag = single ? {33'h0, v[30:0]} : {1'b0, v[62:0]};
   endfunction

   function automatic logic sgn(input logic [63:0] v, input logic single);
      sgn = single ? v[31] : v[63];
   endfunction

   // pins pass two flops first
   fpp_sync #(
      .W  (19),
      .RV (`FPP_SYNC_RST)
   ) u_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({handshake_strobe_n_i, status_line_high, status_line_low, data_i}),
      .q     (sync_q)
   );

   assign spc_s  = sync_q[18];
   assign code_s = sync_q[17:16];
   assign dat_s  = sync_q[15:0];
   // own pulse and its echo are not host cycles
   assign guard  = (state_q == fpp_pkg::ST_PULSE) || (state_q == fpp_pkg::ST_ECHO);
   assign fall   = spc_d1_q & ~spc_s & ~guard;
   assign rise   = ~spc_d1_q & spc_s & ~guard;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         spc_d1_q <= 1'b1;
         code_q   <= `FPP_ST_RSVD;
      end else begin
         spc_d1_q <= spc_s;
         if (fall) begin
            code_q <= code_s;
         end
      end
   end

   // decode of the operation word
   always_comb begin
      fl  = fmt11_q ? opword_q[`FPP_F11] : opword_q[`FPP_F9];
      fs  = fsize(fl);
      is  = isize(opword_q[`FPP_I9]);
      g1r = opword_q[`FPP_GEN1] <= `FPP_GEN_REG_MAX;
      g2r = opword_q[`FPP_GEN2] <= `FPP_GEN_REG_MAX;
      op_c = fpp_pkg::OP_ILL;
      if (fmt11_q) begin
         case (opword_q[`FPP_OP11])
            4'h0: op_c = fpp_pkg::OP_ADD;
            4'h1: op_c = fpp_pkg::OP_MOV;
            4'h2: op_c = fpp_pkg::OP_CMP;
            4'h4: op_c = fpp_pkg::OP_SUB;
            4'h5: op_c = fpp_pkg::OP_NEG;
            4'h8: op_c = fpp_pkg::OP_DIV;
            4'hC: op_c = fpp_pkg::OP_MUL;
            4'hD: op_c = fpp_pkg::OP_ABS;
            default: op_c = fpp_pkg::OP_ILL;
         endcase
      end else begin
         case (opword_q[`FPP_OP9])
            3'h0: op_c = fpp_pkg::OP_I2F;
            3'h1: op_c = fpp_pkg::OP_LDS;
            3'h2: op_c = fpp_pkg::OP_NAR;
            3'h3: op_c = fpp_pkg::OP_WID;
            3'h4: op_c = fpp_pkg::OP_RND;
            3'h5: op_c = fpp_pkg::OP_TRC;
            3'h6: op_c = fpp_pkg::OP_STS;
            default: op_c = fpp_pkg::OP_FLR;
         endcase
      end
      n1 = 3'h0;
      n2 = 3'h0;
      nr = 3'h0;
      case (op_c)
         fpp_pkg::OP_ADD, fpp_pkg::OP_SUB, fpp_pkg::OP_MUL, fpp_pkg::OP_DIV: begin
            n1 = g1r ? 3'h0 : fs;
            n2 = g2r ? 3'h0 : fs;
            nr = g2r ? 3'h0 : fs;
         end
         fpp_pkg::OP_CMP: begin
            n1 = g1r ? 3'h0 : fs;
            n2 = g2r ? 3'h0 : fs;
         end
         fpp_pkg::OP_MOV, fpp_pkg::OP_ABS, fpp_pkg::OP_NEG: begin
            n1 = g1r ? 3'h0 : fs;
            nr = g2r ? 3'h0 : fs;
         end
         fpp_pkg::OP_FLR, fpp_pkg::OP_TRC, fpp_pkg::OP_RND: begin
            n1 = g1r ? 3'h0 : fs;
            nr = is;
         end
         fpp_pkg::OP_WID: begin
            n1 = g1r ? 3'h0 : `FPP_WORDS_2;
            nr = g2r ? 3'h0 : `FPP_WORDS_4;
         end
         fpp_pkg::OP_NAR: begin
            n1 = g1r ? 3'h0 : `FPP_WORDS_4;
            nr = g2r ? 3'h0 : `FPP_WORDS_2;
         end
         fpp_pkg::OP_I2F: begin
            n1 = is;
            nr = g2r ? 3'h0 : fs;
         end
         fpp_pkg::OP_LDS: n1 = `FPP_WORDS_2;
         fpp_pkg::OP_STS: nr = `FPP_WORDS_2;
         default: nr = 3'h0;
      endcase
      ntot = 3'(n1 + n2);
      widx = (wcnt_q < n1) ? wcnt_q : 3'(`FPP_OP2_BASE + wcnt_q - n1);
   end

   // execution: operand moves, sign ops, compare, status register access
   always_comb begin
      a1     = {opm_q[3], opm_q[2], opm_q[1], opm_q[0]};
      a2     = {opm_q[7], opm_q[6], opm_q[5], opm_q[4]};
      eq_c   = (a1 == a2) || (mag(a1, fl) == 64'h0 && mag(a2, fl) == 64'h0);
      gt_c   = !eq_c && ((!sgn(a1, fl) && sgn(a2, fl)) ||
               (!sgn(a1, fl) && !sgn(a2, fl) && mag(a1, fl) > mag(a2, fl)) ||
               (sgn(a1, fl) && sgn(a2, fl) && mag(a1, fl) < mag(a2, fl)));
      res_c  = a1;
      quit_c = inject_q;
      tt_c   = `FPP_TT_ILL;
      case (op_c)
         fpp_pkg::OP_ADD, fpp_pkg::OP_SUB, fpp_pkg::OP_MUL: res_c = a2;
         fpp_pkg::OP_DIV: begin
            res_c = a2;
            if (mag(a1, fl) == 64'h0) begin
               quit_c = 1'b1;
               tt_c   = `FPP_TT_DVZ;
            end
         end
         fpp_pkg::OP_ABS: res_c = fl ? {32'h0, 1'b0, a1[30:0]} : {1'b0, a1[62:0]};
         fpp_pkg::OP_NEG: res_c = fl ? {32'h0, ~a1[31], a1[30:0]} : {~a1[63], a1[62:0]};
         fpp_pkg::OP_STS: res_c = {32'h0, fsr_q};
         fpp_pkg::OP_ILL: quit_c = 1'b1;
         default: res_c = a1;
      endcase
   end

   // protocol events
   assign id_wr = rise && code_q == `FPP_ST_ID;
   assign x_wr  = rise && code_q == `FPP_ST_XFER &&
                  (state_q == fpp_pkg::ST_OPW || state_q == fpp_pkg::ST_OPND);
   assign s_go  = fall && code_s == `FPP_ST_STAT && state_q == fpp_pkg::ST_STAT;
   assign r_go  = fall && code_s == `FPP_ST_XFER && state_q == fpp_pkg::ST_RES;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q  <= fpp_pkg::ST_IDLE;
         fmt11_q  <= 1'b0;
         opword_q <= 16'h0000;
         wcnt_q   <= 3'h0;
         rcnt_q   <= 3'h0;
         cnt_q    <= 8'h00;
      end else if (id_wr) begin
         wcnt_q  <= 3'h0;
         fmt11_q <= dat_s[7:0] == ID_FMT11;
         if (dat_s[7:0] == ID_FMT9 || dat_s[7:0] == ID_FMT11) begin
            state_q <= fpp_pkg::ST_OPW;
         end else begin
            state_q <= fpp_pkg::ST_IDLE;
         end
      end else begin
         case (state_q)
            fpp_pkg::ST_OPW: if (x_wr) begin
               opword_q <= {dat_s[7:0], dat_s[15:8]};
               state_q  <= fpp_pkg::ST_OPND;
            end
            fpp_pkg::ST_OPND: if (wcnt_q == ntot) begin
               state_q <= fpp_pkg::ST_EXEC;
               cnt_q   <= EXEC_CYCLES;
            end else if (x_wr) begin
               wcnt_q <= 3'(wcnt_q + 3'h1);
            end
            fpp_pkg::ST_EXEC: if (cnt_q <= 8'h01) begin
               state_q <= fpp_pkg::ST_PULSE;
               cnt_q   <= `FPP_PULSE_CYC;
            end else begin
               cnt_q <= 8'(cnt_q - 8'h01);
            end
            fpp_pkg::ST_PULSE: if (cnt_q <= 8'h01) begin
               state_q <= fpp_pkg::ST_ECHO;
               cnt_q   <= `FPP_ECHO_CYC;
            end else begin
               cnt_q <= 8'(cnt_q - 8'h01);
            end
            fpp_pkg::ST_ECHO: if (cnt_q <= 8'h01) begin
               state_q <= fpp_pkg::ST_STAT;
            end else begin
               cnt_q <= 8'(cnt_q - 8'h01);
            end
            fpp_pkg::ST_STAT: if (rise && code_q == `FPP_ST_STAT) begin
               rcnt_q <= 3'h0;
               // a quit ends the exchange here
               if (sw_q[`FPP_SW_QUIT] || nr == 3'h0) begin
                  state_q <= fpp_pkg::ST_IDLE;
               end else begin
                  state_q <= fpp_pkg::ST_RES;
               end
            end
            fpp_pkg::ST_RES: if (rise && code_q == `FPP_ST_XFER) begin
               rcnt_q <= 3'(rcnt_q + 3'h1);
               if (3'(rcnt_q + 3'h1) == nr) begin
                  state_q <= fpp_pkg::ST_IDLE;
               end
            end
            default: state_q <= state_q;
         endcase
      end
   end

   // operand store, cleared per instruction so register-mode sources read zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int k = 0; k < 8; k++) begin
            opm_q[k] <= 16'h0000;
         end
      end else if (state_q == fpp_pkg::ST_OPW && x_wr) begin
         for (int k = 0; k < 8; k++) begin
            opm_q[k] <= 16'h0000;
         end
      end else if (state_q == fpp_pkg::ST_OPND && x_wr && wcnt_q != ntot) begin
         if (op_c == fpp_pkg::OP_I2F && opword_q[`FPP_I9] == `FPP_I_BYTE) begin
            opm_q[widx] <= {8'h00, dat_s[7:0]};
         end else begin
            opm_q[widx] <= dat_s;
         end
      end
   end

   // results, status word and float status register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int k = 0; k < 4; k++) begin
            res_q[k] <= 16'h0000;
         end
         sw_q  <= 16'h0000;
         fsr_q <= 32'h0000_0000;
      end else if (state_q == fpp_pkg::ST_EXEC && cnt_q <= 8'h01) begin
         for (int k = 0; k < 4; k++) begin
            res_q[k] <= res_c[16*k +: 16];
         end
         sw_q                 <= 16'h0000;
         sw_q[`FPP_SW_QUIT]   <= quit_c;
         sw_q[`FPP_SW_L]      <= 1'b0;
         if (op_c == fpp_pkg::OP_CMP && !quit_c) begin
            sw_q[`FPP_SW_Z] <= eq_c;
            sw_q[`FPP_SW_N] <= gt_c;
         end
         if (quit_c) begin
            fsr_q[`FPP_TT] <= tt_c;
         end else if (op_c == fpp_pkg::OP_LDS) begin
            fsr_q <= a1[31:0];
         end
      end
   end

   // pin drivers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_o                <= 16'h0000;
         data_oe               <= 1'b0;
         handshake_strobe_n_o  <= 1'b1;
         handshake_strobe_n_oe <= 1'b0;
      end else begin
         if (id_wr || rise || guard) begin
            data_oe <= 1'b0;
         end else if (s_go) begin
            data_o  <= sw_q;
            data_oe <= 1'b1;
         end else if (r_go) begin
            data_o  <= res_q[rcnt_q[1:0]];
            data_oe <= 1'b1;
         end
         handshake_strobe_n_o  <= state_q != fpp_pkg::ST_PULSE;
         handshake_strobe_n_oe <= state_q == fpp_pkg::ST_PULSE;
      end
   end

   // apb slave, no wait states
   always_comb begin
      map_c = 1'b1;
      rd_c  = 32'h0000_0000;
      case (paddr)
         `FPP_A_CTRL:  rd_c = {31'h0, inject_q};
         `FPP_A_STATE: rd_c = {29'h0, state_q};
         `FPP_A_FSR:   rd_c = fsr_q;
         `FPP_A_OPW:   rd_c = {15'h0, fmt11_q, opword_q};
         default:      map_c = 1'b0;
      endcase
   end

   assign pready = 1'b1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata   <= 32'h0000_0000;
         pslverr  <= 1'b0;
         inject_q <= 1'b0;
      end else begin
         if (psel && !penable) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_c;
            pslverr <= !map_c;
         end
         if (psel && penable && pwrite && paddr == `FPP_A_CTRL) begin
            inject_q <= pwdata[0];
         end
      end
   end
endmodule
`default_nettype wire

/* fpp_port_monitor.sv */
`default_nettype none
module fpp_port_monitor (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // host protocol pins
   input wire logic        status_line_low,
   input wire logic        status_line_high,
   input wire logic        handshake_strobe_n_i,
   input wire logic        handshake_strobe_n_o,
   input wire logic        handshake_strobe_n_oe,
   input wire logic [15:0] data_o,
   input wire logic        data_oe
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // host asks for the status word
   sequence s_stat_req;
      $fell(handshake_strobe_n_i) && status_line_high && !status_line_low;
   endsequence
   // one low cycle driven, then let go
   sequence s_done_pulse;
      handshake_strobe_n_oe && !handshake_strobe_n_o ##1 !handshake_strobe_n_oe;
   endsequence
   AST_PULSE_ONE: assert property ($rose(handshake_strobe_n_oe) |-> s_done_pulse)
      else $error("completion pulse is not one low cycle");
   AST_PULSE_IDLE: assert property ($rose(handshake_strobe_n_oe) |-> $past(handshake_strobe_n_i) && !data_oe)
      else $error("strobe driven outside an idle wire");
   AST_STAT_ANSWER: assert property (s_stat_req |-> ##[1:5] data_oe)
      else $error("status read not answered");
   AST_OE_HOLD: assert property (data_oe && !handshake_strobe_n_i |=> data_oe)
      else $error("bus released while strobe low");
   AST_OE_NEEDS_REQ: assert property ($rose(data_oe) |->
                                      !handshake_strobe_n_i && !$past(handshake_strobe_n_i, 2)
                                      && (status_line_low != status_line_high))
      else $error("bus driven without a read cycle");
   AST_OE_DROP: assert property ($rose(handshake_strobe_n_i) && data_oe |-> ##[1:5] !data_oe)
      else $error("bus not released after strobe");
   AST_DATA_STABLE: assert property (data_oe && $past(data_oe) |-> $stable(data_o))
      else $error("read data changed during strobe");
   AST_L_ZERO: assert property (data_oe && status_line_high && !status_line_low |-> !data_o[2])
      else $error("low flag bit set in status word");
   AST_RST_QUIET: assert property ($rose(presetn) |-> !data_oe && !handshake_strobe_n_oe)
      else $error("pins driven right after reset");
endmodule
bind fpp_port fpp_port_monitor i_mon (
   .pclk(pclk), .presetn(presetn), .status_line_low(status_line_low), .status_line_high(status_line_high),
   .handshake_strobe_n_i(handshake_strobe_n_i), .handshake_strobe_n_o(handshake_strobe_n_o),
   .handshake_strobe_n_oe(handshake_strobe_n_oe), .data_o(data_o), .data_oe(data_oe)
);
`default_nettype wire

/* fpp_host_model.sv */
`default_nettype none
module fpp_host_model (
   // clock
   input  wire logic        pclk,
   // device drivers
   input  wire logic        data_oe,
   input  wire logic [15:0] data_o,
   input  wire logic        strobe_oe,
   input  wire logic        strobe_o,
   // resolved wires
   output var  logic        st_lo,
   output var  logic        st_hi,
   output wire logic        strobe_w,
   output wire logic [15:0] data_w
);
   timeunit 1ns;
   timeprecision 1ns;
   logic        h_stb = 1'h1;
   logic        h_soe = 1'h0;
   logic        h_oe  = 1'h0;
   logic [15:0] h_d   = 16'h0;
   logic [15:0] flt_q = 16'h0;
   int          lag   = 0;
   initial begin
      st_lo = 1'h0;
      st_hi = 1'h0;
   end
   // pull-up holds the strobe high when nobody drives it
   assign strobe_w = strobe_oe ? strobe_o : (h_soe ? h_stb : 1'h1);
   // a floating bus shows the inverse of its last level
   assign data_w = data_oe ? data_o : (h_oe ? h_d : flt_q);
   always_ff @(posedge pclk) begin
      flt_q <= ~data_w;
   end
   // one transfer: status and data first, then a strobe pulse
   task automatic cyc(input logic [1:0] st, input logic wr, input logic [15:0] d, output logic [15:0] rd);
      @(posedge pclk);
      st_hi <= st[1];
      st_lo <= st[0];
      h_oe  <= wr;
      h_d   <= d;
      h_soe <= 1'h1;
      @(posedge pclk);
      h_stb <= 1'h0;
      repeat (5 + lag) @(posedge pclk);
      rd = data_w;
      h_stb <= 1'h1;
      repeat (5) @(posedge pclk);
      h_oe  <= 1'h0;
      h_soe <= 1'h0;
   endtask
   // wait for the completion pulse, then the quiet gap
   task automatic wait_done(output logic ok);
      ok = 1'h0;
      for (int i = 0; i < 40 && !ok; i++) begin
         @(posedge pclk);
         ok = (strobe_w === 1'h0);
      end
      repeat (6) @(posedge pclk);
   endtask
endmodule
`default_nettype wire

/* tb_top.sv */
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [7:0]  id;
      logic [15:0] opw;
      logic [3:0]  nin;
      logic [3:0]  nout;
      logic        q;
      logic        chk;
      logic [63:0] din;
      logic [63:0] res;
   } fpp_row_t;
   localparam logic [31:0] A  = 32'hC0A00000;
   localparam logic [31:0] B  = 32'h41200000;
   localparam logic [63:0] C  = 64'h4014000000000001;
   localparam logic [63:0] RA = {32'h0, A};
   localparam logic [63:0] RB = {32'h0, B};
   localparam logic [63:0] AB = {B, A};
   logic        pclk, presetn, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, st_lo, st_hi, stb_o, stb_oe, dat_oe;
   wire  logic  stb_w;
   wire  logic [15:0] dat_w;
   logic [15:0] dat_o;
   int          n_errors = 0;
   int          checks_done = 0;
   // id, opword, words in, words out, quit, check result words, operands, result
   fpp_row_t rows [21] = '{
      '{8'hA5, 16'h8401, 4'h4, 4'h2, 1'h0, 1'h1, AB, RB}, '{8'hA5, 16'h8411, 4'h4, 4'h2, 1'h0, 1'h1, AB, RB},
      '{8'hA5, 16'h8431, 4'h4, 4'h2, 1'h0, 1'h1, AB, RB}, '{8'hA5, 16'h8421, 4'h4, 4'h2, 1'h0, 1'h1, AB, RB},
      '{8'hA5, 16'h8409, 4'h4, 4'h0, 1'h0, 1'h0, AB, 64'h0}, '{8'hA5, 16'h8405, 4'h2, 4'h2, 1'h0, 1'h1, RA, RA},
      '{8'hA5, 16'h8435, 4'h2, 4'h2, 1'h0, 1'h1, RA, 64'h40A00000},
      '{8'hA5, 16'h8415, 4'h2, 4'h2, 1'h0, 1'h1, RB, 64'hC1200000},
      '{8'hA5, 16'h0401, 4'h2, 4'h2, 1'h0, 1'h1, RB, RB}, '{8'hA5, 16'h0400, 4'h4, 4'h4, 1'h0, 1'h1, C, C},
      '{8'h5A, 16'h8407, 4'h2, 4'h2, 1'h0, 1'h1, RA, RA}, '{8'h5A, 16'h843F, 4'h2, 4'h2, 1'h0, 1'h1, RA, RA},
      '{8'h5A, 16'h842F, 4'h2, 4'h2, 1'h0, 1'h1, RA, RA}, '{8'h5A, 16'h8427, 4'h2, 4'h2, 1'h0, 1'h1, RA, RA},
      '{8'h5A, 16'h841B, 4'h2, 4'h4, 1'h0, 1'h0, RA, 64'h0}, '{8'h5A, 16'h8416, 4'h4, 4'h2, 1'h0, 1'h0, C, 64'h0},
      '{8'hA5, 16'h8421, 4'h4, 4'h0, 1'h1, 1'h0, {B, 32'h0}, 64'h0},
      '{8'h5A, 16'h840F, 4'h2, 4'h0, 1'h0, 1'h0, 64'h0, 64'h0},
      '{8'h5A, 16'h8437, 4'h0, 4'h2, 1'h0, 1'h1, 64'h0, 64'h0},
      '{8'h5A, 16'h8404, 4'h1, 4'h2, 1'h0, 1'h1, 64'hAB7E, 64'h7E},
      '{8'hA5, 16'h840D, 4'h0, 4'h0, 1'h1, 1'h0, 64'h0, 64'h0}
   };
   fpp_port #(.EXEC_CYCLES(8'h04)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .status_line_low(st_lo),
      .status_line_high(st_hi), .handshake_strobe_n_i(stb_w), .handshake_strobe_n_o(stb_o),
      .handshake_strobe_n_oe(stb_oe), .data_i(dat_w), .data_o(dat_o), .data_oe(dat_oe)
   );
   fpp_host_model i_host (
      .pclk(pclk), .data_oe(dat_oe), .data_o(dat_o), .strobe_oe(stb_oe), .strobe_o(stb_o),
      .st_lo(st_lo), .st_hi(st_hi), .strobe_w(stb_w), .data_w(dat_w)
   );
   initial begin
      pclk = 1'h0;
      forever #25 pclk = ~pclk;
   end
   task automatic stop_test();
      $display("n_errors=%0d checks_done=%0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                      output logic er);
      @(posedge pclk);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1)
         @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask
   // full instruction: id, swapped opword, operands, pulse, status, result
   task automatic run(input fpp_row_t w);
      logic [15:0] v;
      logic        ok;
      i_host.cyc(2'h3, 1'h1, {8'h00, w.id}, v);
      i_host.cyc(2'h1, 1'h1, {w.opw[7:0], w.opw[15:8]}, v);
      for (int k = 0; k < w.nin; k++)
         i_host.cyc(2'h1, 1'h1, w.din[16*k +: 16], v);
      i_host.wait_done(ok);
      chk({31'h0, ok}, 32'h1);
      i_host.cyc(2'h2, 1'h0, 16'h0, v);
      chk({16'h0, v & 16'h00C5}, {24'h0, (w.nout == 4'h0) ? w.res[7:0] : 8'h00} | {31'h0, w.q});
      for (int k = 0; k < w.nout && !w.q; k++) begin
         i_host.cyc(2'h1, 1'h0, 16'h0, v);
         if (w.chk)
            chk({16'h0, v}, {16'h0, w.res[16*k +: 16]});
      end
   endtask
   initial begin
      fpp_row_t    w;
      logic [31:0] d;
      logic [15:0] v;
      logic        e;
      presetn = 1'h0;
      psel    = 1'h0;
      penable = 1'h0;
      pwrite  = 1'h0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      for (int r = 0; r < 21; r++) begin
         i_host.lag = (r % 2) * 3;
         run(rows[r]);
      end
      // compare flags: greater first, then signed zeros equal
      w = rows[4];
      w.din = {A, B};
      w.res = 64'h80;
      run(w);
      w.din = {32'h80000000, 32'h0};
      w.res = 64'h40;
      run(w);
      // unselected unit stays idle
      i_host.cyc(2'h3, 1'h1, 16'h0033, v);
      i_host.cyc(2'h1, 1'h1, 16'h0584, v);
      apb(1'h0, 8'h04, 32'h0, d, e);
      chk(d & 32'h7, 32'h0);
      // a new id cancels an instruction stuck mid-operands
      i_host.cyc(2'h3, 1'h1, 16'h00A5, v);
      i_host.cyc(2'h1, 1'h1, 16'h0184, v);
      i_host.cyc(2'h1, 1'h1, 16'h1234, v);
      run(rows[5]);
      apb(1'h0, 8'h0C, 32'h0, d, e);
      chk(d, 32'h00018405);
      // forced quit gives no result and returns to idle
      apb(1'h1, 8'h00, 32'h1, d, e);
      apb(1'h0, 8'h00, 32'h0, d, e);
      chk(d, 32'h1);
      w = rows[0];
      w.q = 1'h1;
      run(w);
      apb(1'h1, 8'h00, 32'h0, d, e);
      apb(1'h0, 8'h04, 32'h0, d, e);
      chk(d & 32'h7, 32'h0);
      // zero divisor trap type, read-only status, unmapped address
      run(rows[16]);
      apb(1'h1, 8'h08, 32'h0, d, e);
      apb(1'h0, 8'h08, 32'h0, d, e);
      chk(d & 32'h7, 32'h6);
      apb(1'h0, 8'h10, 32'h0, d, e);
      chk({d[30:0], e}, 32'h1);
      // reset in mid-instruction
      i_host.cyc(2'h3, 1'h1, 16'h00A5, v);
      presetn <= 1'h0;
      repeat (64) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, 8'h08, 32'h0, d, e);
      chk(d, 32'h0);
      apb(1'h0, 8'h04, 32'h0, d, e);
      chk(d & 32'h7, 32'h0);
      run(rows[0]);
      stop_test();
   end
   initial begin
      repeat (30000) @(posedge pclk);
      n_errors++;
      stop_test();
   end
endmodule
`default_nettype wire
